// ===== graphics_clock_source_control.sv
// clock source selection, clock pin functions, sub-carrier output and clock-run handling
// assumes an apb master on clk; pins and reference clocks arrive asynchronously
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "graphics_clock_source_control_regs.svh"

module graphics_clock_source_control
  import graphics_clock_source_control_pkg::*;
#(
  parameter int SYNC_STAGES = 2,
  parameter int ADDR_WIDTH  = 12
) (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [ADDR_WIDTH-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // clock source
  input  wire logic                  clock_source_select,
  input  wire logic                  int_memory_clock,
  input  wire logic                  int_video_clock,
  output logic                       synth_enable,
  output logic                       memory_clock_line,
  output logic                       video_clock_line,
  // memory clock pin
  input  wire logic                  memory_clock_pin_i,
  output logic                       memory_clock_pin_o,
  output logic                       memory_clock_pin_oe_n,
  // video clock pin
  input  wire logic                  video_clock_pin_i,
  output logic                       video_clock_pin_o,
  output logic                       video_clock_pin_oe_n,
  // spread spectrum
  output logic                       modulated_clock_in,
  // reference crystals and sub-carrier
  input  wire logic                  ntsc_reference_input,
  input  wire logic                  pal_reference_input,
  output logic                       subcarrier_out,
  // clock run
  input  wire logic                  pci_busy,
  input  wire logic                  clkrun_n_i,
  output logic                       clkrun_n_o,
  output logic                       clkrun_n_oe_n
);

  initial begin
    if (SYNC_STAGES < 2) $error("SYNC_STAGES must be at least 2");
    if (ADDR_WIDTH < 4 || ADDR_WIDTH > 32) $error("ADDR_WIDTH must lie in 4..32");
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  localparam int NSYNC = 6;
  localparam int S_SEL = 0;
  localparam int S_MEM = 1;
  localparam int S_VID = 2;
  localparam int S_NTSC = 3;
  localparam int S_PAL = 4;
  localparam int S_CRUN = 5;

  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync_out;

  assign async_in = {clkrun_n_i, pal_reference_input, ntsc_reference_input,
                     video_clock_pin_i, memory_clock_pin_i, clock_source_select};

  // every pin is a level from outside clk, so each goes through its own flop chain
  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      logic [SYNC_STAGES-1:0] chain_q;
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          chain_q <= '0;
        end else begin
          chain_q <= {chain_q[SYNC_STAGES-2:0], async_in[g]};
        end
      end
      assign sync_out[g] = chain_q[SYNC_STAGES-1];
    end
  endgenerate

  wire ext_mode    = sync_out[S_SEL];
  wire mem_pin_lvl = sync_out[S_MEM];
  wire vid_pin_lvl = sync_out[S_VID];
  wire clkrun_high = sync_out[S_CRUN];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] pin_function_control_q;
  logic [7:0] clock_run_control_q;
  logic [7:0] subcarrier_control_q;
  logic [31:0] prdata_q;
  logic        slverr_q;

  function automatic logic addr_hit(input logic [ADDR_WIDTH-1:0] a, input logic [11:0] ofs);
    addr_hit = (a == ADDR_WIDTH'(ofs));
  endfunction

  wire hit_pfc = addr_hit(paddr, `PIN_FUNCTION_CONTROL_OFS);
  wire hit_gsr = addr_hit(paddr, `GENERAL_STATUS_REGISTER_OFS);
  wire hit_crc = addr_hit(paddr, `CLOCK_RUN_CONTROL_OFS);
  wire hit_scc = addr_hit(paddr, `SUBCARRIER_CONTROL_OFS);
  wire mapped  = hit_pfc | hit_gsr | hit_crc | hit_scc;
  wire setup   = psel & ~penable;
  wire wr_en   = psel & penable & pwrite & pstrb[0];

  // ----------------------------------------
  // pin modes
  // ----------------------------------------
  pin_mode_t mem_mode;
  pin_mode_t vid_mode;

  // ssc overrides; with it clear each pin falls back to its own bits
  assign mem_mode = pin_function_control_q[`PFC_SSC_BIT]        ? PIN_SSC :
                    pin_function_control_q[`PFC_MEM_STATUS_BIT] ? PIN_STATUS :
                    (!ext_mode && pin_function_control_q[`PFC_MEM_OBSERVE_BIT]) ? PIN_OBSERVE :
                    PIN_FEED;
  assign vid_mode = pin_function_control_q[`PFC_SSC_BIT]        ? PIN_SSC :
                    pin_function_control_q[`PFC_VID_STATUS_BIT] ? PIN_STATUS :
                    (!ext_mode && pin_function_control_q[`PFC_VID_OBSERVE_BIT]) ? PIN_OBSERVE :
                    PIN_FEED;

  // ----------------------------------------
  // clock run
  // ----------------------------------------
  clock_run_state_t cr_q;
  clock_run_state_t cr_d;
  wire crun_en = clock_run_control_q[`CRC_ENABLE_BIT];

  always_comb begin
    cr_d = cr_q;
    case (cr_q)
      CR_IDLE: begin
        if (crun_en && clkrun_high && pci_busy) begin
          cr_d = CR_HOLD;
        end
      end
      CR_HOLD: begin
        // release once the work is done or software withdraws the function
        if (!crun_en || !pci_busy) begin
          cr_d = CR_IDLE;
        end
      end
      default: begin
        cr_d = CR_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // general status readback
  // ----------------------------------------
  logic [7:0] gsr_val;

  always_comb begin
    gsr_val = 8'h00;
    gsr_val[`GSR_SOURCE_BIT]       = ext_mode;
    gsr_val[`GSR_STATUS_FOUR_BIT]  = (mem_mode == PIN_STATUS) & mem_pin_lvl;
    gsr_val[`GSR_STATUS_THREE_BIT] = (vid_mode == PIN_STATUS) & vid_pin_lvl;
  end

  logic [31:0] rd_val;

  assign rd_val = hit_pfc ? {24'h00_0000, pin_function_control_q} :
                  hit_gsr ? {24'h00_0000, gsr_val} :
                  hit_crc ? {24'h00_0000, clock_run_control_q[7:1], cr_q == CR_HOLD} :
                  hit_scc ? {24'h00_0000, subcarrier_control_q} :
                  32'h0000_0000;

  // ----------------------------------------
  // register process
  // ----------------------------------------
  // read data and error are captured in setup, so the access phase needs no wait state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_function_control_q <= `REG_RESET_VALUE;
      clock_run_control_q    <= `REG_RESET_VALUE;
      subcarrier_control_q   <= `REG_RESET_VALUE;
      prdata_q               <= 32'h0000_0000;
      slverr_q               <= 1'b0;
    end else begin
      if (setup) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_val;
        slverr_q <= ~mapped;
      end
      if (wr_en && hit_pfc) begin
        pin_function_control_q <= pwdata[7:0];
      end
      if (wr_en && hit_crc) begin
        clock_run_control_q <= {pwdata[7:1], 1'b0};
      end
      if (wr_en && hit_scc) begin
        subcarrier_control_q <= pwdata[7:0];
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = slverr_q & psel & penable;

  // ----------------------------------------
  // clock and pin outputs
  // ----------------------------------------
  logic synth_en_q;
  logic mclk_line_q;
  logic vclk_line_q;
  logic mem_o_q;
  logic mem_oe_n_q;
  logic vid_o_q;
  logic vid_oe_n_q;
  logic mod_clk_q;
  logic ref_sel;

  assign ref_sel = subcarrier_control_q[`SCC_PAL_BIT] ? sync_out[S_PAL] : sync_out[S_NTSC];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cr_q        <= CR_IDLE;
      synth_en_q  <= 1'b0;
      mclk_line_q <= 1'b0;
      vclk_line_q <= 1'b0;
      mem_o_q     <= 1'b0;
      mem_oe_n_q  <= 1'b1;
      vid_o_q     <= 1'b0;
      vid_oe_n_q  <= 1'b1;
      mod_clk_q   <= 1'b0;
    end else begin
      cr_q        <= cr_d;
      synth_en_q  <= ~ext_mode;
      mclk_line_q <= ext_mode ? mem_pin_lvl : int_memory_clock;
      vclk_line_q <= ext_mode ? vid_pin_lvl : int_video_clock;
      mem_o_q     <= int_memory_clock;
      mem_oe_n_q  <= ~(mem_mode == PIN_OBSERVE);
      vid_o_q     <= (vid_mode == PIN_SSC) ? ref_sel : int_video_clock;
      vid_oe_n_q  <= ~((vid_mode == PIN_OBSERVE) | (vid_mode == PIN_SSC));
      mod_clk_q   <= (mem_mode == PIN_SSC) & mem_pin_lvl;
    end
  end

  assign synth_enable          = synth_en_q;
  assign memory_clock_line     = mclk_line_q;
  assign video_clock_line      = vclk_line_q;
  assign memory_clock_pin_o    = mem_o_q;
  assign memory_clock_pin_oe_n = mem_oe_n_q;
  assign video_clock_pin_o     = vid_o_q;
  assign video_clock_pin_oe_n  = vid_oe_n_q;
  assign modulated_clock_in    = mod_clk_q;
  // open drain: only ever pulls low
  assign clkrun_n_o            = 1'b0;
  assign clkrun_n_oe_n         = ~(cr_q == CR_HOLD);

  // ----------------------------------------
  // sub-carrier
  // ----------------------------------------
  subcarrier_gen #(
    .DIVIDE(`SUBCARRIER_DIVIDE)
  ) u_subcarrier (
    .clk       (clk),
    .arst_n    (arst_n),
    .ref_level (ref_sel),
    .quad_rate (subcarrier_control_q[`SCC_QUAD_BIT]),
    .subcarrier(subcarrier_out)
  );

endmodule

`default_nettype wire

// ===== graphics_clock_source_control_regs.svh
// register offsets, field positions and reset values of the clock source control block
// assumes a 32-bit apb slave with word-aligned registers
`ifndef GRAPHICS_CLOCK_SOURCE_CONTROL_REGS_SVH
`define GRAPHICS_CLOCK_SOURCE_CONTROL_REGS_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define PIN_FUNCTION_CONTROL_OFS    12'h000
`define GENERAL_STATUS_REGISTER_OFS 12'h004
`define CLOCK_RUN_CONTROL_OFS       12'h008
`define SUBCARRIER_CONTROL_OFS      12'h00C

// ----------------------------------------
// fields
// ----------------------------------------
`define PFC_MEM_STATUS_BIT   0
`define PFC_VID_STATUS_BIT   1
`define PFC_MEM_OBSERVE_BIT  2
`define PFC_VID_OBSERVE_BIT  3
`define PFC_SSC_BIT          7
`define GSR_SOURCE_BIT       0
`define GSR_STATUS_FOUR_BIT  1
`define GSR_STATUS_THREE_BIT 2
`define CRC_ENABLE_BIT       5
`define CRC_HOLDING_BIT      0
`define SCC_PAL_BIT          0
`define SCC_QUAD_BIT         5

// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define REG_RESET_VALUE      8'h00
`define SUBCARRIER_DIVIDE    4

`endif

// ===== graphics_clock_source_control_pkg.sv
// types shared by the clock source control block
// assumes nothing of its surroundings
package graphics_clock_source_control_pkg;

  typedef enum logic [1:0] {
    CR_IDLE = 2'b01,
    CR_HOLD = 2'b10
  } clock_run_state_t;

  typedef enum logic [3:0] {
    PIN_FEED    = 4'b0001,
    PIN_STATUS  = 4'b0010,
    PIN_OBSERVE = 4'b0100,
    PIN_SSC     = 4'b1000
  } pin_mode_t;

endpackage

// ===== subcarrier_gen.sv
// colour sub-carrier generator: passes the reference (4x) or divides it by four (1x)
// assumes ref_level is already synchronised to clk and clk is well above twice the reference
`timescale 1ns/1ps
`default_nettype none
`include "graphics_clock_source_control_regs.svh"

module subcarrier_gen #(
  parameter int DIVIDE = `SUBCARRIER_DIVIDE
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic ref_level,
  input  wire logic quad_rate,
  output logic      subcarrier
);

  localparam int CW = $clog2(DIVIDE);

  logic          ref_prev_q;
  logic [CW-1:0] edge_cnt_q;
  logic          div_q;
  logic          out_q;
  wire           ref_rise = ref_level & ~ref_prev_q;

  initial begin
    if (DIVIDE < 2 || (DIVIDE % 2) != 0) $error("subcarrier_gen: DIVIDE must be even and at least 2");
  end

  // 1x output toggles every DIVIDE/2 rising reference edges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ref_prev_q <= 1'b0;
      edge_cnt_q <= '0;
      div_q      <= 1'b0;
      out_q      <= 1'b0;
    end else begin
      ref_prev_q <= ref_level;
      if (ref_rise) begin
        if (edge_cnt_q == CW'(DIVIDE / 2 - 1)) begin
          edge_cnt_q <= '0;
          div_q      <= ~div_q;
        end else begin
          edge_cnt_q <= edge_cnt_q + 1'b1;
        end
      end
      out_q <= quad_rate ? ref_level : div_q;
    end
  end

  assign subcarrier = out_q;

endmodule

`default_nettype wire

// ===== graphics_clock_source_control_properties.sv
// concurrent checks on the clock source control block ports
// assumes the block's reset values and a bench that keeps the select pin driven
`timescale 1ns/1ps
`default_nettype none
module clock_source_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clock_source_select,
  input wire logic synth_enable,
  input wire logic memory_clock_line,
  input wire logic memory_clock_pin_i,
  input wire logic memory_clock_pin_oe_n,
  input wire logic modulated_clock_in,
  input wire logic pci_busy,
  input wire logic clkrun_n_i,
  input wire logic clkrun_n_o,
  input wire logic clkrun_n_oe_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // --------------------------------
  // mode windows
  // --------------------------------
  // long enough for the select pin to clear both sync flops and the output flop
  sequence ext_s;
    clock_source_select [*4];
  endsequence
  sequence int_s;
    !clock_source_select [*4];
  endsequence
  chk_synth_off: assert property (ext_s |-> !synth_enable) else $error("synthesizers run in external mode");
  chk_synth_on: assert property (int_s |-> synth_enable) else $error("synthesizers off in internal mode");
  chk_ext_pin_in: assert property (ext_s |-> memory_clock_pin_oe_n) else $error("memory pin driven in external mode");
  chk_ext_line: assert property (clock_source_select [*5] |-> memory_clock_line == $past(memory_clock_pin_i, 3))
    else $error("memory line not fed from pin");
  chk_mod_input: assert property (modulated_clock_in |-> memory_clock_pin_oe_n) else $error("modulated input while driving");
  chk_clkrun_cause: assert property (!clkrun_n_oe_n |-> $past(pci_busy)) else $error("clkrun held while idle");
  chk_clkrun_low: assert property (!clkrun_n_oe_n |-> !clkrun_n_o) else $error("clkrun driven high");
  chk_clkrun_sample: assert property ($fell(clkrun_n_oe_n) |-> $past(clkrun_n_i, 3) && $past(pci_busy))
    else $error("clkrun pulled without a high sample");
endmodule

bind graphics_clock_source_control clock_source_checker i_chk (
  .clk(clk), .arst_n(arst_n), .clock_source_select(clock_source_select), .synth_enable(synth_enable),
  .memory_clock_line(memory_clock_line), .memory_clock_pin_i(memory_clock_pin_i),
  .memory_clock_pin_oe_n(memory_clock_pin_oe_n), .modulated_clock_in(modulated_clock_in), .pci_busy(pci_busy),
  .clkrun_n_i(clkrun_n_i), .clkrun_n_o(clkrun_n_o), .clkrun_n_oe_n(clkrun_n_oe_n)
);
`default_nettype wire

// ===== board_model.sv
// board around the block: clock oscillators, reference crystals and the central clock master
// assumes the block's pin enables are active low and clkrun has a pull-up
`timescale 1ns/1ps
`default_nettype none
module board_model (
  input  wire logic clk_on,
  input  wire logic mem_lvl,
  input  wire logic vid_lvl,
  input  wire logic stop_req,
  input  wire logic mem_o,
  input  wire logic mem_oe_n,
  input  wire logic vid_o,
  input  wire logic vid_oe_n,
  input  wire logic crun_oe_n,
  output wire logic mem_pin,
  output wire logic vid_pin,
  output logic      ntsc = 1'b0,
  output logic      pal = 1'b0,
  output wire logic clkrun_n
);
  logic mosc = 1'b0;
  logic vosc = 1'b0;
  // off-grid periods so a pin edge lands on a bench clock edge only every 50th toggle, every 25th for pal
  always #13.1 mosc = !mosc;
  always #17.3 vosc = !vosc;
  always #34.9 ntsc = !ntsc;
  always #28.2 pal = !pal;
  // a static level stands in for the oscillator when status levels are read
  assign mem_pin = !mem_oe_n ? mem_o : clk_on ? mosc : mem_lvl;
  assign vid_pin = !vid_oe_n ? vid_o : clk_on ? vosc : vid_lvl;
  // master keeps the line low unless it wants to stop the clock
  assign clkrun_n = (!stop_req || !crun_oe_n) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ===== graphics_clock_source_control_bench.sv
// self-checking bench for the clock source control block
// assumes board_model on the far side and the checker bound in
`timescale 1ns/1ps
`default_nettype none
module graphics_clock_source_control_bench;
  logic        clk, arst_n, psel, penable, pwrite, pready, pslverr, css, imc, ivc, synth, mline, vline;
  logic        mpi, mpo, mpoe_n, vpi, vpo, vpoe_n, mod_in, ntsc, pal, sub, busy, crn_i, crn_o, crn_oe_n;
  logic        clk_on, mlvl, vlvl, stop_req, pr, ps;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb;
  logic [32:0] exp_q[$];
  int          num_errors, checks, i, n_ref, n_sub;

  graphics_clock_source_control i_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clock_source_select(css), .int_memory_clock(imc), .int_video_clock(ivc),
    .synth_enable(synth), .memory_clock_line(mline), .video_clock_line(vline), .memory_clock_pin_i(mpi),
    .memory_clock_pin_o(mpo), .memory_clock_pin_oe_n(mpoe_n), .video_clock_pin_i(vpi), .video_clock_pin_o(vpo),
    .video_clock_pin_oe_n(vpoe_n), .modulated_clock_in(mod_in), .ntsc_reference_input(ntsc),
    .pal_reference_input(pal), .subcarrier_out(sub), .pci_busy(busy), .clkrun_n_i(crn_i),
    .clkrun_n_o(crn_o), .clkrun_n_oe_n(crn_oe_n));
  board_model i_board (.clk_on(clk_on), .mem_lvl(mlvl), .vid_lvl(vlvl), .stop_req(stop_req), .mem_o(mpo),
    .mem_oe_n(mpoe_n), .vid_o(vpo), .vid_oe_n(vpoe_n), .crun_oe_n(crn_oe_n), .mem_pin(mpi), .vid_pin(vpi),
    .ntsc(ntsc), .pal(pal), .clkrun_n(crn_i));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) {imc, ivc} <= {~imc, imc};

  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // --------------------------------
  // apb master: reads queue the expected {pslverr, prdata} for the checker
  // --------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) exp_q.push_back(exp);
    @(posedge clk);
    penable <= 1'b1;
    // the request stands until pready is seen high at a rising edge
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin
      num_errors++;
      report_and_stop();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  always @(posedge clk)
    if (psel && penable && pready && !pwrite) check("read", {pslverr, prdata}, exp_q.pop_front());

  initial begin
    {psel, penable, pwrite, paddr, pwdata, css, imc, ivc, busy, mlvl, vlvl, stop_req, arst_n} = '0;
    pstrb = 4'hf;
    clk_on = 1'b1;
    i = $urandom(32'h3ad2);
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    // reset values, then an unmapped word
    for (i = 0; i < 5; i++) apb(1'b0, 12'(i * 4), 0, {i == 4, 32'h0});
    check("synth", synth, 1);
    apb(1'b1, 12'h000, 32'h0000_000c, 0);
    repeat (2) @(negedge clk);
    check("observe", {mpoe_n, vpoe_n, mpo, vpo}, {2'b00, !imc, imc});
    check("lines", {mline, vline}, {!imc, imc});
    // --------------------------------
    // status inputs at random levels
    // --------------------------------
    clk_on <= 1'b0;
    apb(1'b1, 12'h000, 32'h0000_0003, 0);
    repeat (4) begin
      {vlvl, mlvl} <= 2'($urandom);
      repeat (5) @(posedge clk);
      apb(1'b0, 12'h004, 0, {30'h0, vlvl, mlvl, 1'b0});
    end
    {mlvl, vlvl} <= 2'b10;
    apb(1'b1, 12'h000, 32'h0000_008c, 0);
    repeat (5) @(posedge clk);
    check("ssc pins", {mpoe_n, vpoe_n, mod_in}, 3'b101);
    apb(1'b1, 12'h000, 32'h0000_000c, 0);
    repeat (2) @(posedge clk);
    check("pins back", {mpoe_n, vpoe_n, mod_in}, 3'b000);
    // external clocks: select always driven, never left floating
    clk_on <= 1'b1;
    css <= 1'b1;
    repeat (6) @(posedge clk);
    check("external", {synth, mpoe_n, vpoe_n}, 3'b011);
    apb(1'b0, 12'h004, 0, 33'h1);
    css <= 1'b0;
    // --------------------------------
    // sub-carrier: both references at both rates
    // --------------------------------
    for (i = 0; i < 4; i++) begin
      apb(1'b1, 12'h00c, {26'h0, i[1], 4'h0, i[0]}, 0);
      repeat (20) @(posedge clk);
      n_ref = 0;
      n_sub = 0;
      repeat (2000) begin
        {pr, ps} = {i[0] ? pal : ntsc, sub};
        @(posedge clk);
        n_ref += int'(!pr && (i[0] ? pal : ntsc));
        n_sub += int'(!ps && sub);
      end
      if (!i[1]) n_ref = n_ref / 4;
      check("subcarrier", (n_sub - n_ref) inside {[-2:2]}, 1);
    end
    // clock run: held while busy, left alone when disabled
    apb(1'b1, 12'h008, 32'h0000_0020, 0);
    busy <= 1'b1;
    stop_req <= 1'b1;
    repeat (6) @(posedge clk);
    check("clkrun hold", crn_oe_n, 0);
    apb(1'b0, 12'h008, 0, 33'h21);
    busy <= 1'b0;
    repeat (2) @(posedge clk);
    check("clkrun free", crn_oe_n, 1);
    apb(1'b1, 12'h008, 0, 0);
    busy <= 1'b1;
    repeat (6) @(posedge clk);
    check("clkrun off", crn_oe_n, 1);
    report_and_stop();
  end
endmodule
`default_nettype wire
